// File: common/power_reset_defines.svh
// constants for the power, thermal and reset control block
// assumes a 20 MHz core clock and 16-bit registers on a 15-bit address space
`ifndef POWER_RESET_DEFINES_SVH
`define POWER_RESET_DEFINES_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_CHIP_ID 15'h0000
`define ADDR_REVISION 15'h0001
`define ADDR_POWER_ONE 15'h0002
`define ADDR_POWER_TWO 15'h0003
`define ADDR_STATUS 15'h0011
`define ADDR_OUTPUT_CTRL 15'h002a
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_RIGHT_ADC 11
`define BIT_LEFT_ADC 10
`define BIT_MIC_BIAS 4
`define BIT_MASTER_BIAS 3
`define BIT_RIGHT_LINE 15
`define BIT_LEFT_LINE 14
`define BIT_RIGHT_GAIN 13
`define BIT_LEFT_GAIN 12
`define BIT_RIGHT_SUPPLY 11
`define BIT_LEFT_SUPPLY 10
`define BIT_RIGHT_OUTPUT 7
`define BIT_LEFT_OUTPUT 6
`define BIT_RIGHT_MIXER 3
`define BIT_LEFT_MIXER 2
`define BIT_RIGHT_DAC 1
`define BIT_LEFT_DAC 0
`define BIT_OVERTEMP 15
`define BIT_THERMAL_SD 15
// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define RST_POWER_ONE 16'h0000
`define RST_POWER_TWO 16'h0000
`define RST_OUTPUT_CTRL 16'h8000
`define MASK_POWER_ONE 16'h0c18
`define MASK_POWER_TWO 16'hfccf
`define MASK_OUTPUT_CTRL 16'h8000
`define ZERO_WORD 16'h0000
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define POR_MIN_NS 10600
`define CLK_PERIOD_NS 50
`endif

// File: common/power_reset_pkg.sv
// types for the power, thermal and reset control block
// assumes nothing beyond the defines header
package power_reset_pkg;
    // power-on reset sequencer states
    typedef enum logic [1:0] {
        POR_HOLD = 2'b01,
        POR_RUN = 2'b10
    } por_state_type;
endpackage : power_reset_pkg

// File: design/power_reset_control.sv
// power management, thermal shutdown, power-on and software reset control
// assumes the control-interface decoder delivers one-cycle write strobes
// and level read requests synchronous to core_clk
//
// Summary of operation
// - power one bit 11 enables right ADC
// - power one bit 10 enables left ADC
// - bit 4 mic bias, bit 3 master bias
// - power two bits 15/14 enable line outputs
// - power two bits 13/12 enable speaker gains
// - right speaker needs supply and output bits
// - left speaker needs supply and output bits
// - power two bits 3/2 enable speaker mixers
// - power two bits 1/0 enable DACs
// - status bit 15 shows overtemperature, read-only
// - overtemp pollable, pin output, event source
// - thermal shutdown bit forces speakers off while overtemperature
// - during power-on reset writes are discarded
// - after reset defaults held, writes accepted
// - power-on reset lasts at least 10.6 us
// - either supply low asserts power-on reset
// - write to address zero resets registers
// - address zero reads family identification code
// - address one reads revision in bits 3:0
`timescale 1ns/100ps
`include "power_reset_defines.svh"
module power_reset_control
    import power_reset_pkg::*;
#(
    // family identification code, value arbitrary
    parameter logic [15:0] FAMILY_ID = 16'h1234,
    // silicon revision, value arbitrary
    parameter logic [3:0] REVISION = 4'h0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // supply monitors, high when supply above threshold
    input wire logic ldo_supply_ok,
    input wire logic core_supply_ok,
    // temperature sensor, high when overtemperature
    input wire logic temp_sensor_hot,
    // register access from control interface
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [14:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // power-on reset state, low while held
    output logic por_n,
    // analog enables
    output logic right_adc_enable,
    output logic left_adc_enable,
    output logic mic_bias_enable,
    output logic master_bias_enable,
    output logic right_line_out_enable,
    output logic left_line_out_enable,
    output logic right_spk_gain_enable,
    output logic left_spk_gain_enable,
    output logic right_speaker_output,
    output logic left_speaker_output,
    output logic right_spk_mixer_enable,
    output logic left_spk_mixer_enable,
    output logic right_dac_enable,
    output logic left_dac_enable,
    // temperature status for pin mux and interrupt logic
    output logic overtemp_status,
    output logic overtemp_event
);
    // ----------------------------------------------------------------
    // power-on reset timer
    // ----------------------------------------------------------------
    localparam int POR_CYCLES = (`POR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int CW = $clog2(POR_CYCLES + 1);
    localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);

    por_state_type por_state_q, por_state_d;
    logic [CW-1:0] por_count_q, por_count_d;
    logic supplies_ok;
    logic held;

    assign supplies_ok = ldo_supply_ok & core_supply_ok;
    assign held = (por_state_q == POR_HOLD);

    // hold for the full period even when both supplies rise at once
    always_comb begin
        por_state_d = por_state_q;
        por_count_d = por_count_q;
        unique case (por_state_q)
            POR_HOLD: begin
                if (!supplies_ok) begin
                    por_count_d = '0;
                end else if (por_count_q == POR_LAST) begin
                    por_state_d = POR_RUN;
                end else begin
                    por_count_d = por_count_q + 1'b1;
                end
            end
            POR_RUN: begin
                if (!supplies_ok) begin
                    por_state_d = POR_HOLD;
                    por_count_d = '0;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            por_state_q <= POR_HOLD;
            por_count_q <= '0;
        end else begin
            por_state_q <= por_state_d;
            por_count_q <= por_count_d;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [15:0] power_one_q, power_one_d;
    logic [15:0] power_two_q, power_two_d;
    logic [15:0] output_ctrl_q, output_ctrl_d;
    logic soft_reset_trigger_q, soft_reset_trigger_d;
    logic write_ok;

    assign write_ok = reg_write & ~held;

    // soft reset is a pulse applied one cycle late, so the write itself
    // never competes with the reload
    always_comb begin
        power_one_d = power_one_q;
        power_two_d = power_two_q;
        output_ctrl_d = output_ctrl_q;
        soft_reset_trigger_d = write_ok && (reg_addr == `ADDR_CHIP_ID);
        if (soft_reset_trigger_q) begin
            power_one_d = `RST_POWER_ONE;
            power_two_d = `RST_POWER_TWO;
            output_ctrl_d = `RST_OUTPUT_CTRL;
        end else if (write_ok) begin
            if (reg_addr == `ADDR_POWER_ONE) begin
                power_one_d = reg_wdata & `MASK_POWER_ONE;
            end
            if (reg_addr == `ADDR_POWER_TWO) begin
                power_two_d = reg_wdata & `MASK_POWER_TWO;
            end
            if (reg_addr == `ADDR_OUTPUT_CTRL) begin
                output_ctrl_d = reg_wdata & `MASK_OUTPUT_CTRL;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || held) begin
            power_one_q <= `RST_POWER_ONE;
            power_two_q <= `RST_POWER_TWO;
            output_ctrl_q <= `RST_OUTPUT_CTRL;
            soft_reset_trigger_q <= 1'b0;
        end else begin
            power_one_q <= power_one_d;
            power_two_q <= power_two_d;
            output_ctrl_q <= output_ctrl_d;
            soft_reset_trigger_q <= soft_reset_trigger_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs and readback
    // ----------------------------------------------------------------
    logic hot_q;
    logic shutdown;
    logic [15:0] rdata_d;
    logic [15:0] status_word;

    assign shutdown = output_ctrl_q[`BIT_THERMAL_SD] & hot_q;
    always_comb begin
        status_word = `ZERO_WORD;
        status_word[`BIT_OVERTEMP] = hot_q;
    end

    // readback mux; unmapped and unowned addresses read as zero
    always_comb begin
        rdata_d = reg_rdata;
        if (reg_read) begin
            unique case (reg_addr)
                `ADDR_CHIP_ID: rdata_d = FAMILY_ID;
                `ADDR_REVISION: rdata_d = {12'h000, REVISION};
                `ADDR_POWER_ONE: rdata_d = power_one_q;
                `ADDR_POWER_TWO: rdata_d = power_two_q;
                `ADDR_STATUS: rdata_d = status_word;
                `ADDR_OUTPUT_CTRL: rdata_d = output_ctrl_q;
                default: rdata_d = `ZERO_WORD;
            endcase
        end
    end

    // every output registered; enables lag register by one cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hot_q <= 1'b0;
            reg_rdata <= `ZERO_WORD;
            por_n <= 1'b0;
            right_adc_enable <= 1'b0;
            left_adc_enable <= 1'b0;
            mic_bias_enable <= 1'b0;
            master_bias_enable <= 1'b0;
            right_line_out_enable <= 1'b0;
            left_line_out_enable <= 1'b0;
            right_spk_gain_enable <= 1'b0;
            left_spk_gain_enable <= 1'b0;
            right_speaker_output <= 1'b0;
            left_speaker_output <= 1'b0;
            right_spk_mixer_enable <= 1'b0;
            left_spk_mixer_enable <= 1'b0;
            right_dac_enable <= 1'b0;
            left_dac_enable <= 1'b0;
            overtemp_status <= 1'b0;
            overtemp_event <= 1'b0;
        end else begin
            hot_q <= temp_sensor_hot;
            reg_rdata <= rdata_d;
            por_n <= ~held;
            right_adc_enable <= power_one_q[`BIT_RIGHT_ADC];
            left_adc_enable <= power_one_q[`BIT_LEFT_ADC];
            mic_bias_enable <= power_one_q[`BIT_MIC_BIAS];
            master_bias_enable <= power_one_q[`BIT_MASTER_BIAS];
            right_line_out_enable <= power_two_q[`BIT_RIGHT_LINE];
            left_line_out_enable <= power_two_q[`BIT_LEFT_LINE];
            right_spk_gain_enable <= power_two_q[`BIT_RIGHT_GAIN];
            left_spk_gain_enable <= power_two_q[`BIT_LEFT_GAIN];
            right_speaker_output <= power_two_q[`BIT_RIGHT_SUPPLY]
                & power_two_q[`BIT_RIGHT_OUTPUT] & ~shutdown;
            left_speaker_output <= power_two_q[`BIT_LEFT_SUPPLY]
                & power_two_q[`BIT_LEFT_OUTPUT] & ~shutdown;
            right_spk_mixer_enable <= power_two_q[`BIT_RIGHT_MIXER];
            left_spk_mixer_enable <= power_two_q[`BIT_LEFT_MIXER];
            right_dac_enable <= power_two_q[`BIT_RIGHT_DAC];
            left_dac_enable <= power_two_q[`BIT_LEFT_DAC];
            overtemp_status <= hot_q;
            overtemp_event <= hot_q & ~overtemp_status;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_SPK_SHUTDOWN: assert property (@(posedge core_clk) disable iff (rst)
        (output_ctrl_q[`BIT_THERMAL_SD] && hot_q) |=> !right_speaker_output)
        else $error("speaker on during thermal shutdown");
    AST_RIGHT_SPK: assert property (@(posedge core_clk) disable iff (rst)
        !power_two_q[`BIT_RIGHT_OUTPUT] |=> !right_speaker_output)
        else $error("right speaker on without output bit");
    AST_LEFT_SPK: assert property (@(posedge core_clk) disable iff (rst)
        !power_two_q[`BIT_LEFT_SUPPLY] |=> !left_speaker_output)
        else $error("left speaker on without supply bit");
    AST_SUPPLY_DROP: assert property (@(posedge core_clk) disable iff (rst)
        !supplies_ok |=> held)
        else $error("reset not asserted on supply drop");
    AST_POR_MIN: assert property (@(posedge core_clk) disable iff (rst)
        $rose(por_state_q == POR_RUN) |-> $past(por_count_q) == POR_LAST)
        else $error("power-on reset released early");
    AST_WRITE_DROP: assert property (@(posedge core_clk) disable iff (rst)
        held |=> power_two_q == `RST_POWER_TWO)
        else $error("register changed while held");
    AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (rst)
        (write_ok && reg_addr == `ADDR_CHIP_ID && supplies_ok) |=> ##1
        (power_one_q == `RST_POWER_ONE && output_ctrl_q == `RST_OUTPUT_CTRL))
        else $error("soft reset did not restore defaults");
    AST_STATUS_READ: assert property (@(posedge core_clk) disable iff (rst)
        (reg_read && reg_addr == `ADDR_STATUS) |=> reg_rdata[`BIT_OVERTEMP] == $past(hot_q))
        else $error("status readback wrong");
    AST_ID_READ: assert property (@(posedge core_clk) disable iff (rst)
        (reg_read && reg_addr == `ADDR_CHIP_ID) |=> reg_rdata == FAMILY_ID)
        else $error("family code readback wrong");
    AST_LEFT_SHUTDOWN: assert property (@(posedge core_clk) disable iff (rst)
        shutdown |=> !left_speaker_output)
        else $error("left speaker on during thermal shutdown");
    AST_RIGHT_SUPPLY: assert property (@(posedge core_clk) disable iff (rst)
        !power_two_q[`BIT_RIGHT_SUPPLY] |=> !right_speaker_output)
        else $error("right speaker on without supply bit");
    AST_LEFT_OUTPUT: assert property (@(posedge core_clk) disable iff (rst)
        !power_two_q[`BIT_LEFT_OUTPUT] |=> !left_speaker_output)
        else $error("left speaker on without output bit");
    AST_REV_READ: assert property (@(posedge core_clk) disable iff (rst)
        (reg_read && reg_addr == `ADDR_REVISION) |=> reg_rdata == {12'h000, REVISION})
        else $error("revision readback wrong");
    AST_EVENT_PULSE: assert property (@(posedge core_clk) disable iff (rst)
        overtemp_event |=> !overtemp_event)
        else $error("overtemperature event longer than one cycle");
endmodule : power_reset_control

// File: tb/test_power_reset_control.sv
// self-checking bench for the power, thermal and reset control block
// assumes the design package is compiled first; bench drives all ports
`timescale 1ns/100ps
module test_power_reset_control;
    import power_reset_pkg::*;
    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    localparam logic [15:0] ID_CODE = 16'h5a3c; // arbitrary value
    localparam logic [3:0] REV_CODE = 4'h7; // arbitrary value
    logic core_clk, rst, ldo_supply_ok, core_supply_ok, temp_sensor_hot;
    logic reg_write, reg_read, por_n, overtemp_status, overtemp_event;
    logic [14:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic right_adc_enable, left_adc_enable, mic_bias_enable, master_bias_enable;
    logic right_line_out_enable, left_line_out_enable, right_spk_gain_enable;
    logic left_spk_gain_enable, right_speaker_output, left_speaker_output;
    logic right_spk_mixer_enable, left_spk_mixer_enable, right_dac_enable, left_dac_enable;
    int errors, n_checks, n;
    power_reset_control #(.FAMILY_ID(ID_CODE), .REVISION(REV_CODE)) power_reset_control_inst (
        .core_clk, .rst, .ldo_supply_ok, .core_supply_ok, .temp_sensor_hot,
        .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .por_n,
        .right_adc_enable, .left_adc_enable, .mic_bias_enable, .master_bias_enable,
        .right_line_out_enable, .left_line_out_enable, .right_spk_gain_enable,
        .left_spk_gain_enable, .right_speaker_output, .left_speaker_output,
        .right_spk_mixer_enable, .left_spk_mixer_enable, .right_dac_enable,
        .left_dac_enable, .overtemp_status, .overtemp_event);
    // 50 ns period
    always #25 core_clk = ~core_clk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16
    // one-cycle strobe; a new access waits for the next edge
    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [14:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk16(what, exp, reg_rdata);
    endtask : rd
    // enables lag the register, so give them a few edges
    task automatic chk_outs(input logic [15:0] p1, input logic [15:0] p2, input logic cut);
        repeat (3) @(posedge core_clk);
        #1;
        chk16("power one outputs", {12'h000, p1[11], p1[10], p1[4], p1[3]},
            {12'h000, right_adc_enable, left_adc_enable, mic_bias_enable, master_bias_enable});
        chk16("power two outputs", {6'h00, p2[15:12], p2[3:0],
            p2[11] & p2[7] & !cut, p2[10] & p2[6] & !cut},
            {6'h00, right_line_out_enable, left_line_out_enable, right_spk_gain_enable,
            left_spk_gain_enable, right_spk_mixer_enable, left_spk_mixer_enable,
            right_dac_enable, left_dac_enable, right_speaker_output, left_speaker_output});
    endtask : chk_outs
    // bounded wait for power-on reset release, counts edges
    task automatic wait_por(output int cnt);
        cnt = 0;
        while (por_n !== 1'b1) begin
            @(posedge core_clk);
            #1;
            cnt++;
            if (cnt > 400) begin
                errors++;
                $display("[ERR] por_n expected 1 seen %b", por_n);
                end_of_test();
            end
        end
    endtask : wait_por
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_por;
        wr(15'h0003, 16'hffff);
        wait_por(n);
        chk16("por length ok", 16'h0001, {15'h0, n + 2 >= 212 && n + 2 <= 216});
        rd(15'h0003, 16'h0000, "power two");
        rd(15'h0002, 16'h0000, "power one");
        rd(15'h002a, 16'h8000, "output ctrl");
        rd(15'h0011, 16'h0000, "status");
        chk_outs(16'h0000, 16'h0000, 1'b0);
        $display("test por done");
    endtask : t_por
    task automatic t_ids;
        rd(15'h0000, ID_CODE, "family id");
        rd(15'h0001, {12'h000, REV_CODE}, "revision");
        wr(15'h0001, 16'hffff);
        rd(15'h0001, {12'h000, REV_CODE}, "revision kept");
        wr(15'h0011, 16'hffff);
        rd(15'h0011, 16'h0000, "status kept");
        rd(15'h0005, 16'h0000, "unmapped");
        $display("test ids done");
    endtask : t_ids
    // walk one bit through both registers to catch swapped fields
    task automatic t_power;
        for (int i = 0; i < 16; i++) begin
            wr(15'h0002, 16'h0001 << i);
            wr(15'h0003, 16'h0001 << i);
            chk_outs(16'h0001 << i, 16'h0001 << i, 1'b0);
        end
        wr(15'h0002, 16'hffff);
        rd(15'h0002, 16'h0c18, "power one");
        wr(15'h0003, 16'hffff);
        rd(15'h0003, 16'hfccf, "power two");
        chk_outs(16'hffff, 16'hffff, 1'b0);
        $display("test power done");
    endtask : t_power
    task automatic t_thermal;
        int ev;
        ev = 0;
        wr(15'h0003, 16'h0cc0);
        @(posedge core_clk);
        temp_sensor_hot <= 1'b1;
        repeat (6) begin
            @(posedge core_clk);
            #1;
            ev += int'(overtemp_event === 1'b1);
        end
        chk16("event pulses", 16'h0001, 16'(ev));
        chk16("overtemp_status", 16'h0001, {15'h0, overtemp_status});
        rd(15'h0011, 16'h8000, "status hot");
        chk_outs(16'hffff, 16'h0cc0, 1'b1);
        wr(15'h002a, 16'h0000);
        rd(15'h002a, 16'h0000, "output ctrl");
        chk_outs(16'hffff, 16'h0cc0, 1'b0);
        wr(15'h002a, 16'hffff);
        chk_outs(16'hffff, 16'h0cc0, 1'b1);
        @(posedge core_clk);
        temp_sensor_hot <= 1'b0;
        chk_outs(16'hffff, 16'h0cc0, 1'b0);
        rd(15'h0011, 16'h0000, "status cool");
        $display("test thermal done");
    endtask : t_thermal
    task automatic t_soft;
        wr(15'h002a, 16'h0000);
        wr(15'h0000, 16'hffff);
        rd(15'h0000, ID_CODE, "id after reset");
        rd(15'h0002, 16'h0000, "power one");
        rd(15'h0003, 16'h0000, "power two");
        rd(15'h002a, 16'h8000, "output ctrl");
        chk_outs(16'h0000, 16'h0000, 1'b0);
        $display("test soft reset done");
    endtask : t_soft
    // host keeps the safe speaker order: output bit before supply on the
    // way up, supply cleared first on the way down
    task automatic t_order;
        wr(15'h0000, 16'h0000);
        wr(15'h0002, 16'h0008);
        wr(15'h0003, 16'h000f);
        wr(15'h0003, 16'hf0cf);
        chk_outs(16'h0008, 16'hf0cf, 1'b0);
        wr(15'h0003, 16'hfccf);
        chk_outs(16'h0008, 16'hfccf, 1'b0);
        wr(15'h0003, 16'hf0cf);
        chk_outs(16'h0008, 16'hf0cf, 1'b0);
        wr(15'h0003, 16'hf00f);
        wr(15'h0000, 16'h0000);
        rd(15'h0003, 16'h0000, "power two");
        rd(15'h0002, 16'h0000, "power one");
        chk_outs(16'h0000, 16'h0000, 1'b0);
        $display("test order done");
    endtask : t_order
    // each supply in turn drops, reset returns, defaults reload
    task automatic t_drop;
        for (int k = 0; k < 2; k++) begin
            wr(15'h0003, 16'hffff);
            @(posedge core_clk);
            ldo_supply_ok <= (k != 0);
            core_supply_ok <= (k == 0);
            repeat (3) @(posedge core_clk);
            #1;
            chk16("por_n low", 16'h0000, {15'h0, por_n});
            chk_outs(16'h0000, 16'h0000, 1'b0);
            wr(15'h0003, 16'hffff);
            @(posedge core_clk);
            ldo_supply_ok <= 1'b1;
            core_supply_ok <= 1'b1;
            wait_por(n);
            chk16("por again ok", 16'h0001, {15'h0, n >= 212});
            rd(15'h0003, 16'h0000, "write dropped");
        end
        $display("test supply drop done");
    endtask : t_drop
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        ldo_supply_ok = 1'b1;
        core_supply_ok = 1'b1;
        temp_sensor_hot = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 15'h0000;
        reg_wdata = 16'h0000;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_por();
        t_ids();
        t_power();
        t_thermal();
        t_soft();
        t_order();
        t_drop();
        end_of_test();
    end
endmodule : test_power_reset_control
